/* File: mrac_pkg.sv */
// package: constants and types of the mapped register access core
package mrac_pkg;

  // access port widths
  localparam int ADDR_W  = 16;            // address within one group
  localparam int DATA_W  = 32;            // every transfer is one word
  localparam int GROUP_W = 4;             // map-select group number
  localparam int NARROW_W = 16;           // width of the narrow groups

  // map-select group codes
  localparam logic [3:0] GRP_CTRL   = 4'h0; // control, status, phy management
  localparam logic [3:0] GRP_MAC    = 4'h1; // mac registers, wide
  localparam logic [3:0] GRP_PCS    = 4'h2; // pcs, narrow
  localparam logic [3:0] GRP_PMA    = 4'h3; // pma/pmd, narrow
  localparam logic [3:0] GRP_SCHED  = 4'h4; // scheduler and vendor phy, narrow
  localparam logic [3:0] GRP_VENDOR = 4'hC; // vendor, narrow

  // register addresses inside the control group
  localparam logic [15:0] OFS_ID      = 16'h0000; // constant identity word
  localparam logic [15:0] OFS_CFG     = 16'h0001; // configuration and isolation
  localparam logic [15:0] OFS_LOCK    = 16'h0002; // write-once lock
  localparam logic [15:0] OFS_STATUS  = 16'h0003; // event flags
  localparam logic [15:0] OFS_SCRATCH = 16'h0004; // cleared after read
  localparam logic [15:0] OFS_CMD     = 16'h0005; // self-clearing command
  // address of the single register in the mac and narrow groups
  localparam logic [15:0] OFS_MAC_DATA = 16'h0000;
  localparam logic [15:0] OFS_NARROW   = 16'h0000;

  // field positions
  localparam int CFG_ISO_BIT  = 31; // isolated mode, write zero to leave
  localparam int LOCK_BIT     = 0;  // sticky once written to one
  localparam int CMD_GO_BIT   = 0;  // starts the command
  localparam int ST_CW1_BIT   = 0;  // cleared by writing one
  localparam int ST_CW0_BIT   = 1;  // cleared by writing zero
  localparam int ST_CWANY_BIT = 2;  // cleared by any write
  localparam int ST_LH_BIT    = 3;  // latched high, cleared by read
  localparam int ST_LL_BIT    = 4;  // latched low, restored by read
  localparam int ST_COR_BIT   = 5;  // cleared by read
  localparam int ST_COUNT     = 6;  // number of status flags

  // values after reset
  localparam logic [15:0] CFG_RST     = 16'h0000;
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [31:0] MAC_RST     = 32'h0000_0000;
  localparam logic [15:0] NARROW_RST  = 16'h0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF   = 16'h0000;

  // link bit rate tick
  localparam int CLK_MHZ        = 200; // system clock rate
  localparam int LINK_RATE_MBPS = 10;  // shared medium bit rate
  localparam int BIT_CYCLES     = CLK_MHZ / LINK_RATE_MBPS;
  localparam int DIV_W          = 5;   // holds BIT_CYCLES - 1

  // command sequencer states
  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_RUN  = 1'b1
  } mrac_cmd_state_t;

endpackage : mrac_pkg

/* File: mrac_flag_cell.sv */
// one latched status flag with set-over-clear priority
`timescale 1ns/100ps
module mrac_flag_cell #(
  parameter logic ACTIVE = 1'b1  // level the flag takes on its event
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic event_hit,   // underlying event, one cycle or level
  input  wire logic clear_req,   // host access that restores the flag
  output logic      flag
);

  // whole state of the cell
  typedef struct packed {
    logic q;   // current flag level
  } mrac_flag_state_t;

  mrac_flag_state_t st_reg;   // registered state
  mrac_flag_state_t st_next;  // next state

  // an event in the clearing cycle wins, so no event is lost
  always_comb begin
    st_next = st_reg;
    if (event_hit) begin
      st_next.q = ACTIVE;
    end else if (clear_req) begin
      st_next.q = ~ACTIVE;
    end
  end

  // the flag rests at the inactive level after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg.q <= ~ACTIVE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag = st_reg.q;

endmodule : mrac_flag_cell

/* File: mrac_core.sv */
// register access core: group decode, field semantics, boot strap
`timescale 1ns/100ps
// Summary of operation
// - strap pin sampled during reset selects boot mode
// - strap low gives normal mode, links driven
// - strap high isolates pins until host clears
// - interrupt and register access work while isolated
// - groups zero and one hold wide registers
// - groups two, three, four, twelve are narrow
// - all transfers wide, narrow reads zero-extended
// - narrow writes drop the upper two bytes
// - group plus address selects one register
// - every field returns to default on reset
// - plain field reads back last written value until the lock is set
// - write-once field sticks until reset
// - read-only fields ignore writes, constants fixed
// - clear-on-read flag clears when read
// - clear-on-write flag clears on any write
// - clear-on-value flag clears on matching bit
// - clear-after-read field writable, cleared after read
// - command bit holds until operation completes
// - latched high flag holds one until read
// - latched low flag holds zero until read
// - slave toward host, ten megabit link tick
module mrac_core #(
  parameter int          ADDR_W   = mrac_pkg::ADDR_W,  // in-group address width
  parameter int          DATA_W   = mrac_pkg::DATA_W,  // transfer width
  parameter logic [31:0] ID_VALUE = 32'h0000_0A5A     // arbitrary identity value
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          boot_strap_io,
  input  wire logic                          req_valid,
  input  wire logic                          req_write,
  input  wire logic [mrac_pkg::GROUP_W-1:0]  req_group,
  input  wire logic [ADDR_W-1:0]             req_addr,
  input  wire logic [DATA_W-1:0]             req_wdata,
  output logic                               rsp_valid,
  output logic [DATA_W-1:0]                  rsp_rdata,
  input  wire logic [mrac_pkg::ST_COUNT-1:0] status_events,
  input  wire logic                          cmd_done,
  output logic                               cmd_start,
  output logic                               cmd_busy,
  output logic [15:0]                        cfg_ctrl,
  output logic [DATA_W-1:0]                  mac_word,
  input  wire logic                          link_oe_req,
  output logic                               link_oe,
  input  wire logic                          irq_req,
  output logic                               irq_out,
  output logic                               isolated,
  output logic                               bit_tick
);

  // the decode below is built for these widths only
  if (ADDR_W != 16 || DATA_W != 32) begin : g_bad_width
    $error("mrac_core supports only 16-bit addresses and 32-bit data");
  end

  // whole state of the core
  typedef struct packed {
    logic                            rsp_valid;  // answer strobe
    logic [31:0]                     rsp_rdata;  // answer word
    logic                            iso;        // isolated mode
    logic                            lock;       // write-once lock
    logic [15:0]                     cfg;        // plain control field
    logic [31:0]                     scratch;    // cleared after read
    logic                            cmd_go;     // self-clearing command bit
    mrac_pkg::mrac_cmd_state_t       cst;        // command sequencer
    logic                            cmd_start;  // start pulse
    logic [31:0]                     mac;        // mac group word
    logic [3:0][15:0]                narrow;     // one word per narrow group
    logic [mrac_pkg::DIV_W-1:0]      div;        // bit tick divider
    logic                            tick;       // bit tick pulse
    logic                            link_oe;    // gated pin enable
    logic                            irq;        // interrupt request out
  } mrac_state_t;

  mrac_state_t st_reg;   // registered state
  mrac_state_t st_next;  // next state

  // decoded access strobes
  logic                          rd_hit;        // a read is taken
  logic                          wr_hit;        // a write is taken
  logic                          in_ctrl;       // control group addressed
  logic [2:0]                    narrow_idx;    // narrow slot, 4 when none
  logic [mrac_pkg::ST_COUNT-1:0] flags;         // flag cell outputs
  logic [mrac_pkg::ST_COUNT-1:0] flag_clr;      // flag clear requests
  logic                          st_rd;         // status read
  logic                          st_wr;         // status write

  // maps a narrow group to its storage slot; 4 means not narrow
  function automatic logic [2:0] narrow_slot(input logic [3:0] grp);
    logic [2:0] idx;
    idx = 3'd4;
    case (grp)
      mrac_pkg::GRP_PCS:    idx = 3'd0;
      mrac_pkg::GRP_PMA:    idx = 3'd1;
      mrac_pkg::GRP_SCHED:  idx = 3'd2;
      mrac_pkg::GRP_VENDOR: idx = 3'd3;
      default:              idx = 3'd4;
    endcase
    return idx;
  endfunction : narrow_slot

  // true when the request names this register of the control group
  function automatic logic ctrl_at(input logic [15:0] ofs, input logic [15:0] adr);
    return adr == ofs;
  endfunction : ctrl_at

  // request decode; every request is taken, no wait states
  always_comb begin
    rd_hit     = req_valid && !req_write;
    wr_hit     = req_valid && req_write;
    in_ctrl    = req_group == mrac_pkg::GRP_CTRL;
    narrow_idx = narrow_slot(req_group);
    st_rd      = rd_hit && in_ctrl && ctrl_at(mrac_pkg::OFS_STATUS, req_addr);
    st_wr      = wr_hit && in_ctrl && ctrl_at(mrac_pkg::OFS_STATUS, req_addr);
  end

  // clear conditions of each status flag
  always_comb begin
    flag_clr = '0;
    flag_clr[mrac_pkg::ST_CW1_BIT]   = st_wr && req_wdata[mrac_pkg::ST_CW1_BIT];
    flag_clr[mrac_pkg::ST_CW0_BIT]   = st_wr && !req_wdata[mrac_pkg::ST_CW0_BIT];
    flag_clr[mrac_pkg::ST_CWANY_BIT] = st_wr;
    flag_clr[mrac_pkg::ST_LH_BIT]    = st_rd;
    flag_clr[mrac_pkg::ST_LL_BIT]    = st_rd;
    flag_clr[mrac_pkg::ST_COR_BIT]   = st_rd;
  end

  // status flags; the latched-low one rests high and drops on its event
  for (genvar i = 0; i < mrac_pkg::ST_COUNT; i++) begin : g_flag
    localparam logic ACT = (i == mrac_pkg::ST_LL_BIT) ? 1'b0 : 1'b1;
    mrac_flag_cell #(
      .ACTIVE (ACT)
    ) u_flag (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .event_hit (status_events[i]),
      .clear_req (flag_clr[i]),
      .flag      (flags[i])
    );
  end

  // next state of everything but the flags
  always_comb begin
    st_next           = st_reg;
    st_next.rsp_valid = req_valid;
    st_next.rsp_rdata = mrac_pkg::ZERO_WORD;
    st_next.cmd_start = 1'b0;

    // read path: answer carries the value before any read side effect
    if (rd_hit) begin
      if (in_ctrl) begin
        case (req_addr)
          mrac_pkg::OFS_ID: begin
            st_next.rsp_rdata = ID_VALUE;
          end
          mrac_pkg::OFS_CFG: begin
            st_next.rsp_rdata = {st_reg.iso, 15'h0000, st_reg.cfg};
          end
          mrac_pkg::OFS_LOCK: begin
            st_next.rsp_rdata = {31'h0000_0000, st_reg.lock};
          end
          mrac_pkg::OFS_STATUS: begin
            st_next.rsp_rdata = {26'h000_0000, flags};
          end
          mrac_pkg::OFS_SCRATCH: begin
            st_next.rsp_rdata = st_reg.scratch;
            st_next.scratch   = mrac_pkg::SCRATCH_RST;
          end
          mrac_pkg::OFS_CMD: begin
            st_next.rsp_rdata = {31'h0000_0000, st_reg.cmd_go};
          end
          default: begin
            st_next.rsp_rdata = mrac_pkg::ZERO_WORD;
          end
        endcase
      end else if (req_group == mrac_pkg::GRP_MAC) begin
        if (req_addr == mrac_pkg::OFS_MAC_DATA) begin
          st_next.rsp_rdata = st_reg.mac;
        end
      end else if (narrow_idx != 3'd4) begin
        if (req_addr == mrac_pkg::OFS_NARROW) begin
          // upper bytes always read as zero
          st_next.rsp_rdata = {mrac_pkg::ZERO_HALF, st_reg.narrow[narrow_idx[1:0]]};
        end
      end
    end

    // write path; writes to constants and unmapped words do nothing
    if (wr_hit) begin
      if (in_ctrl) begin
        case (req_addr)
          mrac_pkg::OFS_CFG: begin
            // the lock freezes the control field but never isolation
            if (!st_reg.lock) begin
              st_next.cfg = req_wdata[15:0];
            end
            if (!req_wdata[mrac_pkg::CFG_ISO_BIT]) begin
              st_next.iso = 1'b0;
            end
          end
          mrac_pkg::OFS_LOCK: begin
            st_next.lock = st_reg.lock | req_wdata[mrac_pkg::LOCK_BIT];
          end
          mrac_pkg::OFS_SCRATCH: begin
            st_next.scratch = req_wdata;
          end
          mrac_pkg::OFS_CMD: begin
            // a new start is ignored while one is running
            if (req_wdata[mrac_pkg::CMD_GO_BIT] && st_reg.cst == mrac_pkg::CMD_IDLE) begin
              st_next.cmd_go    = 1'b1;
              st_next.cst       = mrac_pkg::CMD_RUN;
              st_next.cmd_start = 1'b1;
            end
          end
          default: begin
            st_next.cfg = st_reg.cfg;
          end
        endcase
      end else if (req_group == mrac_pkg::GRP_MAC) begin
        if (req_addr == mrac_pkg::OFS_MAC_DATA) begin
          st_next.mac = req_wdata;
        end
      end else if (narrow_idx != 3'd4) begin
        if (req_addr == mrac_pkg::OFS_NARROW) begin
          // the two upper bytes are dropped
          st_next.narrow[narrow_idx[1:0]] = req_wdata[15:0];
        end
      end
    end

    // command sequencer: bit stays set until the operation reports done
    case (st_reg.cst)
      mrac_pkg::CMD_IDLE: begin
        st_next.cst = st_next.cst;
      end
      mrac_pkg::CMD_RUN: begin
        if (cmd_done) begin
          st_next.cmd_go = 1'b0;
          st_next.cst    = mrac_pkg::CMD_IDLE;
        end
      end
      default: begin
        st_next.cst    = mrac_pkg::CMD_IDLE;
        st_next.cmd_go = 1'b0;
      end
    endcase

    // bit tick divider at the link rate
    if (st_reg.div == mrac_pkg::DIV_W'(mrac_pkg::BIT_CYCLES - 1)) begin
      st_next.div  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.div  = st_reg.div + 1'b1;
      st_next.tick = 1'b0;
    end

    // isolation holds link pins undriven, interrupt passes untouched
    st_next.link_oe = link_oe_req && !st_reg.iso;
    st_next.irq     = irq_req;
  end

  // registers; synchronous reset also samples the boot strap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg.rsp_valid <= 1'b0;
      st_reg.rsp_rdata <= mrac_pkg::ZERO_WORD;
      st_reg.iso       <= boot_strap_io;
      st_reg.lock      <= 1'b0;
      st_reg.cfg       <= mrac_pkg::CFG_RST;
      st_reg.scratch   <= mrac_pkg::SCRATCH_RST;
      st_reg.cmd_go    <= 1'b0;
      st_reg.cst       <= mrac_pkg::CMD_IDLE;
      st_reg.cmd_start <= 1'b0;
      st_reg.mac       <= mrac_pkg::MAC_RST;
      st_reg.narrow    <= {4{mrac_pkg::NARROW_RST}};
      st_reg.div       <= '0;
      st_reg.tick      <= 1'b0;
      st_reg.link_oe   <= 1'b0;
      st_reg.irq       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_rdata = st_reg.rsp_rdata;
  assign cmd_start = st_reg.cmd_start;
  assign cmd_busy  = st_reg.cmd_go;
  assign cfg_ctrl  = st_reg.cfg;
  assign mac_word  = st_reg.mac;
  assign link_oe   = st_reg.link_oe;
  assign irq_out   = st_reg.irq;
  assign isolated  = st_reg.iso;
  assign bit_tick  = st_reg.tick;

endmodule : mrac_core

/* File: mrac_core_sva.sv */
// checker: port-level assertions for the register access core
`timescale 1ns/100ps
module mrac_core_sva #(
  parameter int ADDR_W = mrac_pkg::ADDR_W, // in-group address width
  parameter int DATA_W = mrac_pkg::DATA_W  // transfer width
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              boot_strap_io,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic [3:0]        req_group,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic [5:0]        status_events,
  input wire logic              cmd_done,
  input wire logic              cmd_start,
  input wire logic              cmd_busy,
  input wire logic [15:0]       cfg_ctrl,
  input wire logic [DATA_W-1:0] mac_word,
  input wire logic              link_oe_req,
  input wire logic              link_oe,
  input wire logic              irq_req,
  input wire logic              irq_out,
  input wire logic              isolated,
  input wire logic              bit_tick
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // request decodes the properties key on
  wire logic narrow_rd = req_valid && !req_write && (req_group inside {4'h2, 4'h3, 4'h4, 4'hC});
  wire logic unmap_rd  = req_valid && !req_write && req_group > 4'h4 && req_group != 4'hC;
  wire logic leave_wr  = req_valid && req_write && req_group == mrac_pkg::GRP_CTRL
                         && req_addr == mrac_pkg::OFS_CFG && !req_wdata[31];
  a_rsp_follows_req: assert property (req_valid |=> rsp_valid) else $error("no answer");
  a_rsp_needs_req: assert property (rsp_valid |-> $past(req_valid)) else $error("stray answer");
  a_narrow_upper_zero: assert property (narrow_rd |=> rsp_rdata[31:16] == 16'h0000)
    else $error("narrow read upper half not zero");
  a_unmapped_read_zero: assert property (unmap_rd |=> rsp_rdata == '0) else $error("unmapped read");
  a_iso_blocks_link: assert property (isolated && $past(isolated) |-> !link_oe)
    else $error("link enabled while isolated");
  a_iso_holds_on: assert property (isolated && !leave_wr |=> isolated) else $error("isolation lost");
  a_irq_follows_req: assert property ($past(rst_n) |-> irq_out == $past(irq_req))
    else $error("interrupt not passed");
  a_start_sets_busy: assert property (cmd_start |-> cmd_busy) else $error("start without busy");
  a_busy_rise_start: assert property ($rose(cmd_busy) |-> cmd_start) else $error("busy w/o start");
  a_busy_until_done: assert property (cmd_busy && !cmd_done |=> cmd_busy) else $error("busy dropped");
  a_done_ends_busy: assert property (cmd_busy && cmd_done |=> !cmd_busy) else $error("busy stuck");
  a_tick_period_20: assert property (bit_tick |=> !bit_tick ##19 bit_tick)
    else $error("bit tick period wrong");
  c_cmd_done: cover property (cmd_busy && cmd_done);
  c_iso_left: cover property ($fell(isolated));
  c_narrow_rd: cover property (narrow_rd);
endmodule : mrac_core_sva

bind mrac_core mrac_core_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .boot_strap_io(boot_strap_io), .req_valid(req_valid),
  .req_write(req_write), .req_group(req_group), .req_addr(req_addr), .req_wdata(req_wdata),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .status_events(status_events), .cmd_done(cmd_done),
  .cmd_start(cmd_start), .cmd_busy(cmd_busy), .cfg_ctrl(cfg_ctrl), .mac_word(mac_word),
  .link_oe_req(link_oe_req), .link_oe(link_oe), .irq_req(irq_req), .irq_out(irq_out),
  .isolated(isolated), .bit_tick(bit_tick));

/* File: mrac_op_model.sv */
// partner: operation engine that finishes a started command after a delay
`timescale 1ns/100ps
module mrac_op_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       cmd_start, // operation launched by the core
  input  wire logic [3:0] op_delay,  // cycles to completion, zero never completes
  output logic            cmd_done   // one-cycle completion pulse
);
  logic [3:0] cnt_reg; // cycles left in the running operation
  // countdown; done is a pulse so a stale level cannot end a later command
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg  <= 4'h0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= (cnt_reg == 4'h1);
      if (cmd_start) begin
        cnt_reg <= op_delay;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : mrac_op_model

/* File: tb_top.sv */
// testbench: corner cases and random words through the register access core
`timescale 1ns/100ps
module tb_top;
  localparam logic [31:0] ID_VAL = 32'h0000_1234; // arbitrary identity value
  logic        sys_clk, rst_n, boot_strap_io, req_valid, req_write, rsp_valid, cmd_done, cmd_start;
  logic        cmd_busy, link_oe_req, link_oe, irq_req, irq_out, isolated, bit_tick;
  logic [3:0]  req_group, op_delay;
  logic [15:0] req_addr, cfg_ctrl;
  logic [31:0] req_wdata, rsp_rdata, mac_word, rd, w, seed;
  logic [5:0]  status_events;
  logic [31:0] vals [5];                                     // words written per group
  logic [3:0]  grps [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hC};   // wide group first
  logic [3:0]  ugrp [4] = '{4'h5, 4'h0, 4'h1, 4'hF};         // unmapped places
  logic [15:0] uadr [4] = '{16'h0000, 16'h0006, 16'h0001, 16'h0000};
  int          fails, total_checks, cycles, starts;

  mrac_core #(.ID_VALUE(ID_VAL)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .boot_strap_io(boot_strap_io), .req_valid(req_valid),
    .req_write(req_write), .req_group(req_group), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .status_events(status_events), .cmd_done(cmd_done),
    .cmd_start(cmd_start), .cmd_busy(cmd_busy), .cfg_ctrl(cfg_ctrl), .mac_word(mac_word),
    .link_oe_req(link_oe_req), .link_oe(link_oe), .irq_req(irq_req), .irq_out(irq_out),
    .isolated(isolated), .bit_tick(bit_tick));
  mrac_op_model u_op (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_start(cmd_start), .op_delay(op_delay),
    .cmd_done(cmd_done));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // hang guard and command launch counter; run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cmd_start === 1'b1) starts++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // a narrow register keeps the low half and reads back zero-extended
  function automatic logic [31:0] narrow_exp(input logic [31:0] d);
    return {16'h0000, d[15:0]};
  endfunction : narrow_exp
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  // one request held for one edge; answer read 1 ns after the taking edge
  task automatic acc(input logic wr, input logic [3:0] g, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_group = g;
    req_addr  = a;
    req_wdata = d;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    chk_bit(rsp_valid, 1'b1);
    rd = rsp_rdata;
  endtask : acc
  task automatic do_reset(input logic strap);
    @(posedge sys_clk);
    #1;
    rst_n = 1'b0;
    boot_strap_io = strap;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
  endtask : do_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {rst_n, req_valid, req_write, req_group, req_addr, req_wdata, status_events, irq_req} = '0;
    boot_strap_io = 1'b1;
    link_oe_req = 1'b1;
    op_delay = 4'h3;
    seed = 32'h0000_B379; // 45945
    do_reset(1'b1);
    chk_bit(isolated, 1'b1);
    irq_req = 1'b1;
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_ID, 32'h0000_0000);
    chk_word(rd, ID_VAL);
    chk_bit(irq_out, 1'b1);
    chk_bit(link_oe, 1'b0);
    irq_req = 1'b0;
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CFG, 32'h8000_0000);
    chk_bit(irq_out, 1'b0);
    chk_bit(isolated, 1'b1);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CFG, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(link_oe, 1'b1);
    link_oe_req = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(link_oe, 1'b0);
    link_oe_req = 1'b1;
    $display("test isolation done");
    w = xs();
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CFG, w);
    chk_word({16'h0000, cfg_ctrl}, narrow_exp(w));
    chk_bit(isolated, 1'b0);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CFG, 32'h0000_0000);
    chk_word(rd, narrow_exp(w));
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_ID, xs());
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_ID, 32'h0000_0000);
    chk_word(rd, ID_VAL);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_LOCK, 32'h0000_0001);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_LOCK, 32'h0000_0000);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_LOCK, 32'h0000_0000);
    chk_bit(rd[0], 1'b1);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CFG, ~w);
    chk_word({16'h0000, cfg_ctrl}, narrow_exp(w));
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_SCRATCH, w);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_SCRATCH, 32'h0000_0000);
    chk_word(rd, w);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_SCRATCH, 32'h0000_0000);
    chk_word(rd, 32'h0000_0000);
    $display("test field kinds done");
    foreach (grps[i]) begin
      vals[i] = xs();
      acc(1'b1, grps[i], 16'h0000, vals[i]);
    end
    foreach (grps[i]) begin
      acc(1'b0, grps[i], 16'h0000, 32'h0000_0000);
      chk_word(rd, (i == 0) ? vals[i] : narrow_exp(vals[i]));
    end
    foreach (ugrp[i]) begin
      acc(1'b1, ugrp[i], uadr[i], xs());
      acc(1'b0, ugrp[i], uadr[i], 32'h0000_0000);
      chk_word(rd, 32'h0000_0000);
    end
    chk_word(mac_word, vals[0]);
    $display("test groups done");
    @(posedge sys_clk);
    #1;
    status_events = 6'h3F;
    @(posedge sys_clk);
    #1;
    status_events = 6'h00;
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_002F);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_0017);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0002);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_0013);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0003);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_0012);
    acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_0010);
    $display("test status flags done");
    starts = 0;
    for (int k = 1; k <= 3; k++) begin
      w = xs();
      op_delay = 4'h2 + {1'b0, w[2:0]};
      acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CMD, 32'h0000_0001);
      chk_bit(cmd_busy, 1'b1);
      acc(1'b1, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CMD, 32'h0000_0001);
      for (int n = 0; n < 40 && cmd_busy !== 1'b0; n++) @(posedge sys_clk);
      #1;
      chk_word(32'(starts), 32'(k));
      acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_CMD, 32'h0000_0000);
      chk_bit(rd[0], 1'b0);
    end
    $display("test command done");
    do_reset(1'b0);
    chk_bit(isolated, 1'b0);
    chk_word({16'h0000, cfg_ctrl}, 32'h0000_0000);
    repeat (19) @(posedge sys_clk);
    #1;
    chk_bit(bit_tick, 1'b0);
    @(posedge sys_clk);
    #1;
    chk_bit(bit_tick, 1'b1);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_LOCK, 32'h0000_0000);
    chk_bit(rd[0], 1'b0);
    acc(1'b0, mrac_pkg::GRP_CTRL, mrac_pkg::OFS_STATUS, 32'h0000_0000);
    chk_word(rd, 32'h0000_0010);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_top
